// >>> common/lhs_defs.svh
/*
 * Register offsets, field positions, reset values and widths of the
 * lead-off and core health status block.
 * Assumes inclusion by bare name from any file that needs them.
 */
`ifndef LHS_DEFS_SVH
`define LHS_DEFS_SVH

// ----------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------
`define LHS_IDX_CTRL     8'h01
`define LHS_IDX_LEADOFF  8'h1D
`define LHS_IDX_HEALTH   8'h1E
`define LHS_IDX_IRQSTAT  8'h30
`define LHS_IDX_IRQMASK  8'h31
`define LHS_ADDR_W       12
`define LHS_DATA_W       32
`define LHS_REG_W        24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LHS_CTRL_POWER_ENABLE_BIT   1
`define LHS_OVER_HI      23
`define LHS_OVER_LO      18
`define LHS_OVER_CE      13
`define LHS_UNDER_HI     12
`define LHS_UNDER_LO     7
`define LHS_UNDER_CE     2
`define LHS_H_INTERR     3
`define LHS_H_CFGBUSY    2
`define LHS_H_LOSTLOCK   1
`define LHS_H_LOCKED     0
`define LHS_IRQ_LEADOFF  0
`define LHS_IRQ_LOSTLOCK 1
`define LHS_IRQ_INTERR   2

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define LHS_NUM_ELEC     7
`define LHS_SYNC_W       15
`define LHS_IRQ_W        3
`define LHS_REG_RST      24'h00_0000
`define LHS_IRQ_RST      3'h0
`define LHS_RDATA_RST    32'h0000_0000

`endif

// >>> common/lhs_pkg.sv
/*
 * Types shared by the lead-off and core health status block.
 * Assumes nothing of its surroundings.
 */
package lhs_pkg;

	typedef enum logic [1:0] {
		LHS_PLL_OFF,
		LHS_PLL_WAIT,
		LHS_PLL_LOCKED
	} lhs_pll_state_t;

	typedef enum logic {
		LHS_CFG_BUSY,
		LHS_CFG_READY
	} lhs_cfg_t;

	typedef enum logic [2:0] {
		LHS_SEL_NONE,
		LHS_SEL_CTRL,
		LHS_SEL_LEADOFF,
		LHS_SEL_HEALTH,
		LHS_SEL_IRQSTAT,
		LHS_SEL_IRQMASK
	} lhs_sel_t;

endpackage

// >>> common/lhs_lock_if.sv
/*
 * Carrier between the register block and the PLL lock monitor.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/100ps
interface lhs_lock_if;
	logic lockLive;
	logic power_enable_bit;
	logic healthRead;
	logic lostLock;
	logic lossEvt;
	logic lockedNow;

	modport top (
		output lockLive,
		output power_enable_bit,
		output healthRead,
		input  lostLock,
		input  lossEvt,
		input  lockedNow
	);

	modport mon (
		input  lockLive,
		input  power_enable_bit,
		input  healthRead,
		output lostLock,
		output lossEvt,
		output lockedNow
	);
endinterface

// >>> logic/lhs_sync.sv
/*
 * Two-flop synchroniser for the comparator and PLL lock levels.
 * Assumes the inputs are levels from outside the mclk domain.
 */
`timescale 1ns/100ps
`include "lhs_defs.svh"
module lhs_sync (
	input  wire logic                     mclk,
	input  wire logic                     nrst,
	input  wire logic [`LHS_SYNC_W-1:0]   din,
	output logic      [`LHS_SYNC_W-1:0]   dout
);
	logic [`LHS_SYNC_W-1:0] meta;

	// The first stage feeds the second stage only.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// >>> logic/lhs_pll_monitor.sv
/*
 * PLL lock monitor: tracks enable and lock, keeps the sticky lost-lock flag.
 * Assumes lockLive is already synchronised to mclk.
 */
`timescale 1ns/100ps
module lhs_pll_monitor (
	input  wire logic mclk,
	input  wire logic nrst,
	lhs_lock_if.mon   lk
);
	lhs_pkg::lhs_pll_state_t state;

	// ----------------------------------------
	// Lock tracking
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= lhs_pkg::LHS_PLL_OFF;
		end else if (!lk.power_enable_bit) begin
			state <= lhs_pkg::LHS_PLL_OFF;
		end else begin
			unique case (state)
				lhs_pkg::LHS_PLL_OFF:    state <= lhs_pkg::LHS_PLL_WAIT;
				lhs_pkg::LHS_PLL_WAIT:   if (lk.lockLive) state <= lhs_pkg::LHS_PLL_LOCKED;
				lhs_pkg::LHS_PLL_LOCKED: if (!lk.lockLive) state <= lhs_pkg::LHS_PLL_WAIT;
				default:                 state <= lhs_pkg::LHS_PLL_OFF;
			endcase
		end
	end

	// Loss counts only once the PLL was enabled and had locked.
	assign lk.lossEvt = lk.power_enable_bit && (state == lhs_pkg::LHS_PLL_LOCKED) && !lk.lockLive;

	// ----------------------------------------
	// Sticky flag; a loss in the clearing cycle wins
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lk.lostLock <= 1'b0;
		end else if (lk.lossEvt) begin
			lk.lostLock <= 1'b1;
		end else if (lk.healthRead || !lk.power_enable_bit) begin
			lk.lostLock <= 1'b0;
		end
	end

	assign lk.lockedNow = lk.lockLive;
endmodule

// >>> logic/lhs_top.sv
/*
 * Lead-off comparator status and core health status registers with an
 * APB slave, interrupt status and mask, and the power enable control.
 * Assumes an APB master on mclk, comparator and PLL lock levels from
 * other domains, and coreFault as a same-domain level from the core.
 */
`timescale 1ns/100ps
`include "lhs_defs.svh"

module lhs_top (
	input  wire logic                          mclk,
	input  wire logic                          nrst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [`LHS_ADDR_W-1:0]        paddr,
	input  wire logic [`LHS_DATA_W-1:0]        pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [`LHS_DATA_W-1:0]        prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [`LHS_NUM_ELEC-1:0]      compOver,
	input  wire logic [`LHS_NUM_ELEC-1:0]      compUnder,
	input  wire logic                          pllLockIn,
	input  wire logic                          coreFault,
	output logic                               pllEnable,
	output logic                               irq
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Byte address of a register index.
	function automatic logic [`LHS_ADDR_W-1:0] regAddr(input logic [7:0] idx);
		regAddr = {2'b00, idx, 2'b00};
	endfunction

	// Register select from a bus address.
	function automatic lhs_pkg::lhs_sel_t decode(input logic [`LHS_ADDR_W-1:0] a);
		if (a == regAddr(`LHS_IDX_CTRL)) begin
			decode = lhs_pkg::LHS_SEL_CTRL;
		end else if (a == regAddr(`LHS_IDX_LEADOFF)) begin
			decode = lhs_pkg::LHS_SEL_LEADOFF;
		end else if (a == regAddr(`LHS_IDX_HEALTH)) begin
			decode = lhs_pkg::LHS_SEL_HEALTH;
		end else if (a == regAddr(`LHS_IDX_IRQSTAT)) begin
			decode = lhs_pkg::LHS_SEL_IRQSTAT;
		end else if (a == regAddr(`LHS_IDX_IRQMASK)) begin
			decode = lhs_pkg::LHS_SEL_IRQMASK;
		end else begin
			decode = lhs_pkg::LHS_SEL_NONE;
		end
	endfunction

	// Write strobe of one register: a write access to it with the low byte enabled.
	function automatic logic wrHit(
		input logic              wr,
		input lhs_pkg::lhs_sel_t s,
		input lhs_pkg::lhs_sel_t target,
		input logic              lowByte
	);
		wrHit = wr && (s == target) && lowByte;
	endfunction

	// Places the comparator levels into the lead-off layout.
	// Index 6 is right leg drive, then left arm, left leg, right arm,
	// chest one, chest two; index 0 is the common electrode.
	function automatic logic [`LHS_REG_W-1:0] placeFlags(
		input logic [`LHS_NUM_ELEC-1:0] over,
		input logic [`LHS_NUM_ELEC-1:0] under
	);
		logic [`LHS_REG_W-1:0] v;
		v = `LHS_REG_RST;
		v[`LHS_OVER_HI:`LHS_OVER_LO]   = over[`LHS_NUM_ELEC-1:1];
		v[`LHS_OVER_CE]                = over[0];
		v[`LHS_UNDER_HI:`LHS_UNDER_LO] = under[`LHS_NUM_ELEC-1:1];
		v[`LHS_UNDER_CE]               = under[0];
		placeFlags = v;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [`LHS_SYNC_W-1:0]   syncIn;
	logic [`LHS_SYNC_W-1:0]   syncOut;
	logic [`LHS_NUM_ELEC-1:0] overSync;
	logic [`LHS_NUM_ELEC-1:0] underSync;
	logic                     lockSync;

	logic [`LHS_REG_W-1:0]    leadOff;
	logic [`LHS_REG_W-1:0]    next_leadOff;
	logic [`LHS_REG_W-1:0]    health;
	logic                     intErr;
	logic                     intErrPrev;
	lhs_pkg::lhs_cfg_t        cfgState;

	logic                     power_enable_bit;
	logic [`LHS_IRQ_W-1:0]    irqStatus;
	logic [`LHS_IRQ_W-1:0]    irqMask;
	logic [`LHS_IRQ_W-1:0]    irqEvents;

	lhs_pkg::lhs_sel_t        sel;
	logic                     setupPhase;
	logic                     accessPhase;
	logic                     wrAccess;
	logic                     rdAccess;
	logic [`LHS_DATA_W-1:0]   next_prdata;

	lhs_lock_if               lockBus ();

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------

	// Comparators and the lock detector run off the analog side, so their
	// levels are resynchronised before any flag or state looks at them.
	assign syncIn = {compOver, compUnder, pllLockIn};

	lhs_sync u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.din  (syncIn),
		.dout (syncOut)
	);

	assign overSync  = syncOut[`LHS_SYNC_W-1 -: `LHS_NUM_ELEC];
	assign underSync = syncOut[`LHS_NUM_ELEC:1];
	assign lockSync  = syncOut[0];

	// ----------------------------------------
	// Lead-off status
	// ----------------------------------------

	// Flags follow the comparators level for level, so a flag drops back
	// to 0 as soon as its electrode returns to the normal side.
	assign next_leadOff = placeFlags(overSync, underSync);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			leadOff <= `LHS_REG_RST;
		end else begin
			leadOff <= next_leadOff;
		end
	end

	// ----------------------------------------
	// PLL lock monitor
	// ----------------------------------------
	assign lockBus.lockLive   = lockSync;
	assign lockBus.power_enable_bit      = power_enable_bit;

	// Clear only a lost-lock that the read actually returned; a loss that
	// lands between setup and access is kept for the next read.
	assign lockBus.healthRead = rdAccess && (sel == lhs_pkg::LHS_SEL_HEALTH)
	                            && prdata[`LHS_H_LOSTLOCK];

	lhs_pll_monitor u_pll_mon (
		.mclk (mclk),
		.nrst (nrst),
		.lk   (lockBus)
	);

	assign pllEnable = power_enable_bit;

	// ----------------------------------------
	// Internal error
	// ----------------------------------------

	// Sticky until reset: software has no documented way to clear it.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			intErr <= 1'b0;
		end else if (coreFault) begin
			intErr <= 1'b1;
		end
	end

	// The delayed copy turns the sticky flag into a single event for the
	// interrupt status, so a held fault does not keep re-raising it.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			intErrPrev <= 1'b0;
		end else begin
			intErrPrev <= intErr;
		end
	end

	// ----------------------------------------
	// Configuration status
	// ----------------------------------------

	// Any write to the control register applies the configuration.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cfgState <= lhs_pkg::LHS_CFG_BUSY;
		end else begin
			unique case (cfgState)
				lhs_pkg::LHS_CFG_BUSY: begin
					if (wrAccess && sel == lhs_pkg::LHS_SEL_CTRL) begin
						cfgState <= lhs_pkg::LHS_CFG_READY;
					end
				end
				lhs_pkg::LHS_CFG_READY: begin
					cfgState <= lhs_pkg::LHS_CFG_READY;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Health register
	// ----------------------------------------
	always_comb begin
		// Bits above the four health flags are reserved and read 0.
		health                   = `LHS_REG_RST;
		health[`LHS_H_INTERR]    = intErr;
		health[`LHS_H_CFGBUSY]   = (cfgState == lhs_pkg::LHS_CFG_BUSY);
		health[`LHS_H_LOSTLOCK]  = lockBus.lostLock;
		health[`LHS_H_LOCKED]    = lockBus.lockedNow;
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------

	// Only the low byte holds control bits, so the other strobes are ignored.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			power_enable_bit <= 1'b0;
		end else if (wrHit(wrAccess, sel, lhs_pkg::LHS_SEL_CTRL, pstrb[0])) begin
			power_enable_bit <= pwdata[`LHS_CTRL_POWER_ENABLE_BIT];
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------

	// Events: a lead-off flag newly raised, lock lost, internal error raised.
	always_comb begin
		irqEvents                    = `LHS_IRQ_RST;
		irqEvents[`LHS_IRQ_LEADOFF]  = |(next_leadOff & ~leadOff);
		irqEvents[`LHS_IRQ_LOSTLOCK] = lockBus.lossEvt;
		irqEvents[`LHS_IRQ_INTERR]   = intErr && !intErrPrev;
	end

	// Write one to clear; an event in the same cycle wins over the clear.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irqStatus <= `LHS_IRQ_RST;
		end else if (wrHit(wrAccess, sel, lhs_pkg::LHS_SEL_IRQSTAT, pstrb[0])) begin
			irqStatus <= (irqStatus & ~pwdata[`LHS_IRQ_W-1:0]) | irqEvents;
		end else begin
			irqStatus <= irqStatus | irqEvents;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irqMask <= `LHS_IRQ_RST;
		end else if (wrHit(wrAccess, sel, lhs_pkg::LHS_SEL_IRQMASK, pstrb[0])) begin
			irqMask <= pwdata[`LHS_IRQ_W-1:0];
		end
	end

	// The output is registered so that it cannot glitch while status and
	// mask settle; the price is one edge of latency after a clear or a mask write.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irqStatus | irqEvents) & irqMask);
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------

	// Zero wait states: read data is captured in the setup cycle so that
	// it comes from a flip-flop during the access cycle.
	assign sel         = decode(paddr);
	assign setupPhase  = psel && !penable;
	assign accessPhase = psel && penable;
	assign wrAccess    = accessPhase && pwrite;
	assign rdAccess    = accessPhase && !pwrite;
	assign pready      = 1'b1;

	// The health word is returned only on an explicit read of its address.
	always_comb begin
		next_prdata = `LHS_RDATA_RST;
		unique case (sel)
			lhs_pkg::LHS_SEL_CTRL: begin
				next_prdata[`LHS_CTRL_POWER_ENABLE_BIT] = power_enable_bit;
			end
			lhs_pkg::LHS_SEL_LEADOFF: begin
				next_prdata[`LHS_REG_W-1:0] = leadOff;
			end
			lhs_pkg::LHS_SEL_HEALTH: begin
				next_prdata[`LHS_REG_W-1:0] = health;
			end
			lhs_pkg::LHS_SEL_IRQSTAT: begin
				next_prdata[`LHS_IRQ_W-1:0] = irqStatus;
			end
			lhs_pkg::LHS_SEL_IRQMASK: begin
				next_prdata[`LHS_IRQ_W-1:0] = irqMask;
			end
			lhs_pkg::LHS_SEL_NONE: begin
				next_prdata = `LHS_RDATA_RST;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prdata <= `LHS_RDATA_RST;
		end else if (setupPhase && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// Unmapped addresses answer with an error; writes to the read-only
	// status words are ignored without one.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pslverr <= 1'b0;
		end else if (setupPhase) begin
			pslverr <= (sel == lhs_pkg::LHS_SEL_NONE);
		end else if (!psel) begin
			pslverr <= 1'b0;
		end
	end

endmodule

// >>> verification/lhs_checker.sv
/*
 * Port checker for lhs_top, bound after the module.
 * Assumes the slave loads prdata at the setup edge of an APB read.
 */
`timescale 1ns/100ps
module lhs_checker (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [6:0]  compOver,
	input wire logic [6:0]  compUnder,
	input wire logic        pllLockIn,
	input wire logic        coreFault,
	input wire logic        pllEnable,
	input wire logic        irq
);
	localparam logic [11:0] aCtrl = 12'h004;
	localparam logic [11:0] aLoff = 12'h074;
	localparam logic [11:0] aHlth = 12'h078;
	logic faultSeen;
	logic cfgDone;

	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			faultSeen <= 1'b0;
		else if (coreFault)
			faultSeen <= 1'b1;
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			cfgDone <= 1'b0;
		else if (psel && penable && pwrite && paddr == aCtrl)
			cfgDone <= 1'b1;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_rd(logic [11:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	// Flags need three edges to cross, so four stable cycles leave margin.
	sequence s_steady(v);
		$stable(v)[*4];
	endsequence

	a_over_map: assert property (s_steady(compOver) ##0 s_rd(aLoff) |=>
		prdata[23:18] == $past(compOver[6:1]) && prdata[13] == $past(compOver[0]))
		else $error("overrange flags wrong");
	a_under_map: assert property (s_steady(compUnder) ##0 s_rd(aLoff) |=>
		prdata[12:7] == $past(compUnder[6:1]) && prdata[2] == $past(compUnder[0]))
		else $error("underrange flags wrong");
	a_reserved_zero: assert property (s_rd(aLoff) |=>
		prdata[31:24] == 8'h00 && prdata[17:14] == 4'h0 && prdata[6:3] == 4'h0
		&& prdata[1:0] == 2'h0) else $error("reserved bits not zero");
	a_lock_live: assert property (s_steady(pllLockIn) ##0 s_rd(aHlth) |=>
		prdata[0] == $past(pllLockIn)) else $error("lock bit wrong");
	a_fault_flag: assert property (s_rd(aHlth) |=>
		prdata[3] == $past(faultSeen)) else $error("internal error bit wrong");
	a_cfg_busy: assert property (s_rd(aHlth) |=>
		prdata[2] == !$past(cfgDone)) else $error("config bit wrong");
	a_lost_off: assert property ((!pllEnable)[*2] ##0 s_rd(aHlth) |=>
		!prdata[1]) else $error("lost lock with power off");
	a_power_enable_bit_ctrl: assert property (psel && penable && pwrite && pstrb[0]
		&& paddr == aCtrl |=> pllEnable == $past(pwdata[1])) else $error("enable wrong");
endmodule

bind lhs_top lhs_checker chk (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr, .compOver, .compUnder, .pllLockIn, .coreFault,
	.pllEnable, .irq);

// >>> verification/lhs_top_tb.sv
/*
 * Self-checking bench for lhs_top over APB.
 * Assumes the checker is bound in from its own file.
 */
`timescale 1ns/100ps
module lhs_top_tb;
	localparam logic [11:0] aCtrl = 12'h004;
	localparam logic [11:0] aLoff = 12'h074;
	localparam logic [11:0] aHlth = 12'h078;
	localparam logic [11:0] aStat = 12'h0C0;
	localparam logic [11:0] aMask = 12'h0C4;
	logic        mclk;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [6:0]  compOver;
	logic [6:0]  compUnder;
	logic        pllLockIn;
	logic        coreFault;
	logic        pllEnable;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          errorCnt;
	int          testsRun;
	int          cycles;

	lhs_top dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .compOver, .compUnder, .pllLockIn, .coreFault,
		.pllEnable, .irq);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task conclude;
		$display("errors %0d, checks %0d", errorCnt, testsRun);
		if (errorCnt == 0 && testsRun > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			errorCnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Starts on an edge of its own so back-to-back calls never drive twice at once.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdChk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, rd, err);
		check(rd, exp);
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles > 5000) begin
			errorCnt++;
			conclude();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{compOver, compUnder, pllLockIn, coreFault} = '0;
		errorCnt = 0;
		testsRun = 0;
		cycles = 0;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		rdChk(aLoff, 32'h0000_0000);
		rdChk(aHlth, 32'h0000_0004);
		rdChk(aStat, 32'h0000_0000);
		rdChk(aMask, 32'h0000_0000);
		apb(1'b1, aLoff, 32'hFFFF_FFFF, rd, err);
		rdChk(aLoff, 32'h0000_0000);
		apb(1'b0, 12'h100, 32'h0000_0000, rd, err);
		check({31'h0, err}, 32'h0000_0001);
		check(rd, 32'h0000_0000);
		apb(1'b1, aCtrl, 32'h0000_0002, rd, err);
		// The enable register updates at the access edge, so look one edge later.
		@(posedge mclk);
		check({31'h0, pllEnable}, 32'h0000_0001);
		rdChk(aCtrl, 32'h0000_0002);
		rdChk(aHlth, 32'h0000_0000);
		for (int i = 0; i < 7; i++) begin
			compOver <= 7'(1 << i);
			repeat (4) @(posedge mclk);
			rdChk(aLoff, 32'h0000_0001 << (i == 0 ? 13 : 17 + i));
			compOver <= 7'h00;
			compUnder <= 7'(1 << i);
			repeat (4) @(posedge mclk);
			rdChk(aLoff, 32'h0000_0001 << (i == 0 ? 2 : 6 + i));
			compUnder <= 7'h00;
		end
		compOver <= 7'h7F;
		repeat (4) @(posedge mclk);
		rdChk(aLoff, 32'h00FC_2000);
		compUnder <= 7'h7F;
		repeat (4) @(posedge mclk);
		rdChk(aLoff, 32'h00FC_3F84);
		{compOver, compUnder} <= '0;
		repeat (4) @(posedge mclk);
		rdChk(aLoff, 32'h0000_0000);
		rdChk(aStat, 32'h0000_0001);
		check({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, aMask, 32'h0000_0001, rd, err);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, aStat, 32'h0000_0001, rd, err);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, 32'h0000_0000);
		rdChk(aStat, 32'h0000_0000);
		pllLockIn <= 1'b1;
		repeat (4) @(posedge mclk);
		rdChk(aHlth, 32'h0000_0001);
		pllLockIn <= 1'b0;
		repeat (4) @(posedge mclk);
		rdChk(aHlth, 32'h0000_0002);
		rdChk(aHlth, 32'h0000_0000);
		pllLockIn <= 1'b1;
		repeat (4) @(posedge mclk);
		rdChk(aHlth, 32'h0000_0001);
		pllLockIn <= 1'b0;
		repeat (4) @(posedge mclk);
		check({31'h0, irq}, 32'h0000_0000);
		rdChk(aStat, 32'h0000_0002);
		apb(1'b1, aCtrl, 32'h0000_0000, rd, err);
		rdChk(aHlth, 32'h0000_0000);
		apb(1'b1, aStat, 32'h0000_0007, rd, err);
		coreFault <= 1'b1;
		@(posedge mclk);
		coreFault <= 1'b0;
		repeat (2) @(posedge mclk);
		rdChk(aHlth, 32'h0000_0008);
		rdChk(aHlth, 32'h0000_0008);
		rdChk(aStat, 32'h0000_0004);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		rdChk(aHlth, 32'h0000_0004);
		rdChk(aMask, 32'h0000_0000);
		conclude();
	end
endmodule
